// [inc/gpio_port_cfg.svh]
/*
 * Address map, reset values and widths of the eight-pin port.
 * Assumes a 32-bit AHB-Lite data path with word-aligned registers.
 */
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH

`define PIN_COUNT 8
`define ADDR_WORD_LSB 2
`define ADDR_MASK_MSB 9
`define ADDR_DEC_MSB 11
`define OFS_PORT_DATA 12'h000
`define OFS_DATA_LAST 12'h3fc
`define OFS_PIN_DIRECTION 12'h400
`define OFS_IRQ_SENSE 12'h404
`define OFS_IRQ_DUAL_EDGE 12'h408
`define OFS_IRQ_POLARITY 12'h40c
`define OFS_IRQ_MASK 12'h410
`define OFS_IRQ_RAW 12'h414
`define OFS_IRQ_MASKED 12'h418
`define OFS_IRQ_CLEAR 12'h41c
`define RST_PORT_DATA 8'h00
`define RST_PIN_DIRECTION 8'h00
`define RST_IRQ_CFG 8'h00

`endif

// [inc/gpio_port_pkg.sv]
/*
 * Types of the eight-pin port: its whole register state as one struct.
 * Assumes gpio_port_cfg.svh is on the include path.
 */
`include "gpio_port_cfg.svh"

package gpio_port_pkg;

    typedef logic [`PIN_COUNT-1:0] pins_type;

    typedef struct packed {
        pins_type port_data;
        pins_type pin_direction;
        pins_type sense_bits;
        pins_type dual_edge_bits;
        pins_type polarity_bits;
        pins_type irq_mask_enable;
        pins_type irq_raw_status;
        pins_type sync_a;
        pins_type sync_b;
        pins_type sync_prev;
        logic wr_pend;
        logic [`ADDR_DEC_MSB:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        pins_type pin_out;
        pins_type pin_oe_n;
        pins_type pin_irq;
        logic port_irq;
    } gpio_state_type;

endpackage : gpio_port_pkg

// [src/gpio_port.sv]
/*
 * Eight-pin general-purpose port with address-masked data access,
 * per-pin direction and edge/level interrupt detection, AHB-Lite slave.
 * Assumes a single 100 MHz clock, asynchronous pin inputs, and a
 * testbench that resolves each pad from pin_out and pin_oe_n.
 */
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_cfg.svh"

// How it works
// - A data write changes only bits whose mask bit, haddr 9:2, is one.
// - A data read gives zero for each bit whose address mask bit is zero.
// - A data read gives written values on outputs, pin levels on inputs.
// - Written data reaches a pin only when the pin is set as an output.
// - The data register answers at 256 word offsets, the offset the mask.
// - Every register keeps its per-pin bits in 7:0, the rest unused.
// - A direction bit of one makes an output; reset makes all inputs.
// - A sense bit of one selects level detection, zero edge detection.
// - In edge mode a dual-edge bit of one flags both edges, any polarity.
// - Polarity one picks rising edges or high levels, zero the opposite.
// - Reset clears sense, dual-edge and polarity: single falling edges.
// - A trigger raises its pin and port interrupt only when unmasked.
// - Raw status is pre-mask; writing one to a clear bit drops its latch.
module gpio_port
    import gpio_port_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [`PIN_COUNT-1:0] pin_in,
    output logic [`PIN_COUNT-1:0] pin_out,
    output logic [`PIN_COUNT-1:0] pin_oe_n,
    output logic [`PIN_COUNT-1:0] pin_irq,
    output logic combined_port_irq
);

    gpio_state_type state_r;
    gpio_state_type state_nxt;

    logic addr_take;
    logic [`ADDR_DEC_MSB:0] rd_addr;
    pins_type wr_mask;
    pins_type rd_mask;
    pins_type wdata;
    pins_type clear_bits;
    pins_type rise;
    pins_type fall;
    pins_type edge_hit;
    pins_type level_hit;
    pins_type trigger;
    pins_type data_view;
    logic [31:0] rd_word;

    // Only whole-word transfers are issued; hsize needs no decode
    assign addr_take = hsel & htrans[1] & hready;
    assign rd_addr = haddr[`ADDR_DEC_MSB:0];

    always_comb begin
        state_nxt = state_r;
        wdata = hwdata[`PIN_COUNT-1:0];
        wr_mask = state_r.wr_addr[`ADDR_MASK_MSB:`ADDR_WORD_LSB];
        rd_mask = rd_addr[`ADDR_MASK_MSB:`ADDR_WORD_LSB];
        clear_bits = '0;

        // Second flop feeds logic; first is read by it alone
        state_nxt.sync_a = pin_in;
        state_nxt.sync_b = state_r.sync_a;
        state_nxt.sync_prev = state_r.sync_b;

        // Data phase of a write captured in the previous cycle
        if (state_r.wr_pend) begin
            if (state_r.wr_addr <= `OFS_DATA_LAST) begin
                // Every word offset in the data window is the same register
                state_nxt.port_data = (state_r.port_data & ~wr_mask)
                    | (wdata & wr_mask);
            end else begin
                unique case (state_r.wr_addr)
                    `OFS_PIN_DIRECTION: state_nxt.pin_direction = wdata;
                    `OFS_IRQ_SENSE: state_nxt.sense_bits = wdata;
                    `OFS_IRQ_DUAL_EDGE: state_nxt.dual_edge_bits = wdata;
                    `OFS_IRQ_POLARITY: state_nxt.polarity_bits = wdata;
                    `OFS_IRQ_MASK: state_nxt.irq_mask_enable = wdata;
                    `OFS_IRQ_CLEAR: clear_bits = wdata;
                    default: ;
                endcase
            end
        end

        // Edges from two successive synchronised samples
        rise = state_r.sync_b & ~state_r.sync_prev;
        fall = ~state_r.sync_b & state_r.sync_prev;
        edge_hit = (state_r.dual_edge_bits & (rise | fall))
            | (~state_r.dual_edge_bits
               & ((state_r.polarity_bits & rise)
                  | (~state_r.polarity_bits & fall)));
        level_hit = (state_r.polarity_bits & state_r.sync_b)
            | (~state_r.polarity_bits & ~state_r.sync_b);
        trigger = (state_r.sense_bits & level_hit)
            | (~state_r.sense_bits & edge_hit);

        // Edge latches are sticky and a new edge beats a clear in the same
        // cycle; level pins simply follow the live condition.
        state_nxt.irq_raw_status = trigger
            | (state_r.irq_raw_status & ~clear_bits
               & ~state_r.sense_bits);

        state_nxt.pin_irq = state_nxt.irq_raw_status
            & state_nxt.irq_mask_enable;
        state_nxt.port_irq = |state_nxt.pin_irq;

        // Drive only pins set as outputs; enable is active low
        state_nxt.pin_out = state_nxt.port_data;
        state_nxt.pin_oe_n = ~state_nxt.pin_direction;

        // Read data is built from next state so a read right after a
        // write to the same register sees the written value.
        data_view = (state_nxt.pin_direction & state_nxt.port_data)
            | (~state_nxt.pin_direction & state_r.sync_b);
        rd_word = '0;
        if (rd_addr <= `OFS_DATA_LAST) begin
            rd_word[`PIN_COUNT-1:0] = data_view & rd_mask;
        end else begin
            unique case (rd_addr)
                `OFS_PIN_DIRECTION:
                    rd_word[`PIN_COUNT-1:0] = state_nxt.pin_direction;
                `OFS_IRQ_SENSE:
                    rd_word[`PIN_COUNT-1:0] = state_nxt.sense_bits;
                `OFS_IRQ_DUAL_EDGE:
                    rd_word[`PIN_COUNT-1:0] = state_nxt.dual_edge_bits;
                `OFS_IRQ_POLARITY:
                    rd_word[`PIN_COUNT-1:0] = state_nxt.polarity_bits;
                `OFS_IRQ_MASK:
                    rd_word[`PIN_COUNT-1:0] = state_nxt.irq_mask_enable;
                `OFS_IRQ_RAW:
                    rd_word[`PIN_COUNT-1:0] = state_nxt.irq_raw_status;
                `OFS_IRQ_MASKED:
                    rd_word[`PIN_COUNT-1:0] = state_nxt.pin_irq;
                default: rd_word = '0;
            endcase
        end

        // Zero-wait slave: every transfer completes in one data phase
        state_nxt.wr_pend = addr_take & hwrite;
        state_nxt.wr_addr = {rd_addr[`ADDR_DEC_MSB:`ADDR_WORD_LSB], 2'b00};
        if (addr_take & ~hwrite) begin
            state_nxt.hrdata = rd_word;
        end
        state_nxt.hreadyout = 1'b1;
        state_nxt.hresp = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= '0;
            state_r.port_data <= `RST_PORT_DATA;
            state_r.pin_direction <= `RST_PIN_DIRECTION;
            state_r.sense_bits <= `RST_IRQ_CFG;
            state_r.dual_edge_bits <= `RST_IRQ_CFG;
            state_r.polarity_bits <= `RST_IRQ_CFG;
            // Enables are active low, so they start as the inverse
            state_r.pin_oe_n <= ~`RST_PIN_DIRECTION;
            state_r.hreadyout <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign hreadyout = state_r.hreadyout;
    assign hrdata = state_r.hrdata;
    assign hresp = state_r.hresp;
    assign pin_out = state_r.pin_out;
    assign pin_oe_n = state_r.pin_oe_n;
    assign pin_irq = state_r.pin_irq;
    assign combined_port_irq = state_r.port_irq;

endmodule : gpio_port

`default_nettype wire

// [testbench/gpio_port_asserts.sv]
/* Checker on the port's bus answer, pin and interrupt outputs.
   Assumes it is bound to every gpio_port instance. */
`timescale 1ns/10ps
`default_nettype none
module gpio_port_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic hready,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_irq,
    input wire logic combined_port_irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_ready: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_rsv_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("reserved read bits set");
    a_irq_or: assert property (combined_port_irq == |pin_irq)
        else $error("port irq not the or of pin irqs");
    a_dir_rst: assert property
        ($rose(hresetn) |-> pin_oe_n == 8'hff)
        else $error("pins not inputs after reset");
    a_out_rst: assert property
        ($rose(hresetn) |-> pin_out == 8'h00)
        else $error("pin values not clear after reset");
    a_irq_rst: assert property
        ($rose(hresetn) |-> pin_irq == 8'h00)
        else $error("pin irqs set after reset");
    a_irq_cause: assert property
        ($changed(combined_port_irq) |-> $changed(pin_irq))
        else $error("port irq moved alone");
    a_dir_write: assert property
        ($changed(pin_oe_n) |-> $past(htrans[1] && hwrite, 2))
        else $error("enables changed without a write");
    a_rd_masked: assert property
        (hsel && hready && htrans[1] && !hwrite && haddr[11:10] == 2'h0
         |=> (hrdata[7:0] & ~$past(haddr[9:2])) == 8'h00)
        else $error("masked-off data bits read back set");
    a_dir_read: assert property
        (hsel && hready && htrans[1] && !hwrite && haddr[11:0] == 12'h400
         |=> hrdata[7:0] == ~pin_oe_n)
        else $error("direction read disagrees with enables");
    a_out_read: assert property
        (hsel && hready && htrans[1] && !hwrite && haddr[11:2] == 10'h0ff
         |=> ((hrdata[7:0] ^ pin_out) & ~pin_oe_n) == 8'h00)
        else $error("output pin read differs from driven value");
    a_mis_read: assert property
        (hsel && hready && htrans[1] && !hwrite && haddr[11:0] == 12'h418
         |=> hrdata[7:0] == pin_irq)
        else $error("masked status read differs from pin irqs");
endmodule : gpio_port_asserts
bind gpio_port gpio_port_asserts u_gpio_port_asserts (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .hready(hready),
    .htrans(htrans),
    .hwrite(hwrite),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_irq(pin_irq),
    .combined_port_irq(combined_port_irq)
);
`default_nettype wire

// [testbench/gpio_pads.sv]
/* Pad model: an enabled output wins, else the outside drive.
   Assumes the bench sets the outside level for input pins. */
`timescale 1ns/10ps
`default_nettype none
module gpio_pads (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] drive,
    output logic [7:0] pad_level
);
    assign pad_level = (pin_oe_n & drive) | (~pin_oe_n & pin_out);
endmodule : gpio_pads
`default_nettype wire

// [testbench/gpio_port_data_irq_config_tb.sv]
/* Bench of the eight-pin port: reads queue their expected data.
   Assumes gpio_pads resolves each pad. */
`timescale 1ns/10ps
`default_nettype none
module gpio_port_data_irq_config_tb;
    logic hclk = 0, hresetn = 0, hwrite = 0, rd_ph = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rnd = 32'he64c97e5;
    logic [7:0] ext = 0, pad, pin_out, pin_oe_n, pin_irq, pd;
    logic hreadyout, hresp, irq;
    logic [31:0] expq[$];
    int n_fail = 0, check_count = 0;
    always #5 hclk = ~hclk;
    gpio_port u_gpio_port (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pin_in(pad), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_irq(pin_irq), .combined_port_irq(irq));
    gpio_pads u_gpio_pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .drive(ext), .pad_level(pad));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // For a read, d is the expected data, not bus data
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        if (!w) expq.push_back(d);
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
    endtask : xfer
    always @(posedge hclk) begin
        if (rd_ph) check(hrdata, expq.pop_front(), "read data");
        rd_ph <= htrans[1] && !hwrite && hreadyout && hresetn;
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        check(pin_oe_n, 8'hff, "pin enables");
        for (int i = 0; i < 4; i++) begin
            xfer(0, 12'h400 + 12'(4 * i), 0);
        end
        xfer(1, 12'h400, 32'hffffffff);
        pd = 0;
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            pd = (pd & ~rnd[7:0]) | (rnd[15:8] & rnd[7:0]);
            xfer(1, {2'h0, rnd[7:0], 2'h0}, {24'h0, rnd[15:8]});
            xfer(0, {2'h0, rnd[23:16], 2'h0},
                 {24'h0, pd & rnd[23:16]});
        end
        #1 check(pad, pd, "pad levels");
        @(posedge hclk);
        xfer(1, 12'h400, 32'hffffff0f);
        ext <= rnd[31:24];
        xfer(0, 12'h400, 32'h0f);
        repeat (3) @(posedge hclk);
        xfer(0, 12'h3fc, {24'h0, rnd[31:28], pd[3:0]});
        #1 check(pad, {rnd[31:28], pd[3:0]}, "mixed pads");
        @(posedge hclk);
        xfer(1, 12'h400, 0);
        xfer(1, 12'h404, 32'hc0);
        xfer(1, 12'h408, 32'h30);
        xfer(1, 12'h40c, 32'ha5);
        ext <= 0;
        repeat (4) @(posedge hclk);
        xfer(1, 12'h41c, 32'hff);
        xfer(0, 12'h414, 32'h40);
        ext <= 8'hff;
        repeat (4) @(posedge hclk);
        xfer(0, 12'h414, 32'hb5);
        xfer(1, 12'h410, 32'hff);
        #1 check(irq, 1, "port irq");
        check(pin_irq, 8'hb5, "pin irqs");
        @(posedge hclk);
        xfer(1, 12'h41c, 32'hff);
        xfer(0, 12'h414, 32'h80);
        ext <= 0;
        repeat (4) @(posedge hclk);
        xfer(0, 12'h418, 32'h7a);
        xfer(1, 12'h41c, 32'h02);
        xfer(1, 12'h41c, 32'h00);
        xfer(0, 12'h414, 32'h78);
        xfer(1, 12'h410, 0);
        xfer(0, 12'h418, 0);
        #1 check(irq, 0, "masked irq");
        check(pin_irq, 8'h00, "pin irqs off");
        end_sim;
    end
    // The sequence needs under a thousand cycles; this leaves margin
    initial begin
        repeat (3000) @(posedge hclk);
        n_fail++;
        end_sim;
    end
endmodule : gpio_port_data_irq_config_tb
`default_nettype wire
